// File: hdl/dfm_defines.svh
// Constants of the drive fault manager: timing, fault codes, register map.
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DFM_CLK_KHZ 250000
`define DFM_BLINK_MS 200
`define DFM_PAUSE_MS 1200
`define DFM_OVERSPEED_RPM 16'h1388
`define DFM_PHASE_LAST 6'h31

// ----------------------------------------------------------------------
// Fault codes, equal to the lamp blink count; the system code lights the lamp steadily
// ----------------------------------------------------------------------
`define DFM_CODE_NONE 4'h0
`define DFM_CODE_OVERCURRENT 4'h5
`define DFM_CODE_OVERSPEED 4'h6
`define DFM_CODE_MEMORY 4'h7
`define DFM_CODE_SYSTEM 4'h9
`define DFM_OVERSPEED_BIT 5
`define DFM_NUM_CODED 8

// ----------------------------------------------------------------------
// Register map, byte addresses, and field positions
// ----------------------------------------------------------------------
`define DFM_ADDR_STATUS 4'h0
`define DFM_ADDR_IRQ_STATUS 4'h4
`define DFM_ADDR_IRQ_CLEAR 4'h8
`define DFM_ADDR_IRQ_ENABLE 4'hC
`define DFM_ST_ACTIVE 4
`define DFM_ST_DUAL 5
`define DFM_ST_WIND 6
`define DFM_IRQ_RAISE 0
`define DFM_IRQ_CLEARED 1
`define DFM_IRQ_BITS 2

`endif

// File: hdl/dfm_pkg.sv
// Types shared by the drive fault manager.
package dfm_pkg;

   typedef enum logic [2:0] {
      DFM_LAMP_IDLE = 3'b000,
      DFM_LAMP_ON = 3'b001,
      DFM_LAMP_OFF = 3'b010,
      DFM_LAMP_PAUSE = 3'b011,
      DFM_LAMP_STEADY = 3'b100
   } dfm_lamp_state_t;

   typedef struct packed {
      logic fwd;
      logic rev;
      logic step;
      logic dir;
      logic coff;
      logic mult;
      logic clr;
      logic mode;
   } dfm_host_pins_t;

endpackage

// File: hdl/dfm_top.sv
// Drive fault manager: fault latch, lamp code, pulse input and registers.
// Functional notes
// - A fault drops fault output, lights lamp, cuts current; else high.
// - A short pulse on fault_clear_in clears a clearable latched fault.
// - Power-up reset clears every fault and raises the fault output.
// - Overcurrent, memory and system faults ignore fault_clear_in.
// - Lamp blinks N times, 0.2 s lit, 0.2 s dark, 1.2 s pause.
// - Blink count 1 to 8 names the fault type.
// - A system fault lights the lamp steadily.
// - Shaft speed above 5000 r/min raises the overspeed fault.
// - Current-off input removes winding excitation while asserted.
// - Dual-pulse mode makes no step while both pulse inputs are high.
// - Single-pulse mode: direction high clockwise, low counter-clockwise.
// - Timing output may stay low while the multiplier input is low.
// - Pulse mode is sampled only at power-up.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dfm_defines.svh"

module dfm_top #(
   parameter int unsigned BLINK_CYCLES = `DFM_BLINK_MS * `DFM_CLK_KHZ,
   parameter int unsigned PAUSE_CYCLES = `DFM_PAUSE_MS * `DFM_CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic fault_clear_in,
   input wire logic forward_pulse_in,
   input wire logic reverse_pulse_in,
   input wire logic step_pulse_in,
   input wire logic direction_in,
   input wire logic current_off_in,
   input wire logic step_multiplier_in,
   input wire logic dual_pulse_mode,
   input wire logic [7:0] fault_event_in,
   input wire logic system_fault_in,
   input wire logic [15:0] motor_speed_rpm_in,
   output logic fault_out,
   output logic fault_lamp_out,
   output logic winding_enable_out,
   output logic step_out,
   output logic step_dir_out,
   output logic step_phase_timing_out,
   output logic irq,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // The chains carry no reset so that the mode switch is already settled
   // in the first cycle after reset is released.
   dfm_pkg::dfm_host_pins_t pins_raw;
   dfm_pkg::dfm_host_pins_t meta_q;
   dfm_pkg::dfm_host_pins_t sync_q;
   dfm_pkg::dfm_host_pins_t prev_q;

   assign pins_raw.fwd = forward_pulse_in;
   assign pins_raw.rev = reverse_pulse_in;
   assign pins_raw.step = step_pulse_in;
   assign pins_raw.dir = direction_in;
   assign pins_raw.coff = current_off_in;
   assign pins_raw.mult = step_multiplier_in;
   assign pins_raw.clr = fault_clear_in;
   assign pins_raw.mode = dual_pulse_mode;

   always_ff @(posedge sys_clk)
   begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         prev_q <= '0;
      else
         prev_q <= sync_q;
   end

   logic clear_edge;
   assign clear_edge = sync_q.clr & ~prev_q.clr;

   // ----------------------------------------------------------------------
   // Pulse mode strap
   // ----------------------------------------------------------------------
   logic mode_valid_q;
   logic dual_mode_q;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         mode_valid_q <= 1'b0;
         dual_mode_q <= 1'b0;
      end
      else if (!mode_valid_q)
      begin
         mode_valid_q <= 1'b1;
         dual_mode_q <= sync_q.mode;
      end
   end

   // ----------------------------------------------------------------------
   // Fault latch
   // ----------------------------------------------------------------------
   logic overspeed;
   logic [7:0] event_vec;
   logic [3:0] new_code;
   logic [3:0] fault_code_q;
   logic fault_act;
   logic clearable;
   logic clear_ok;

   assign overspeed = motor_speed_rpm_in > `DFM_OVERSPEED_RPM;

   always_comb
   begin
      event_vec = fault_event_in;
      event_vec[`DFM_OVERSPEED_BIT] = fault_event_in[`DFM_OVERSPEED_BIT]
         | overspeed;
   end

   // A system fault outranks the coded ones; among those the lowest wins.
   always_comb
   begin
      new_code = `DFM_CODE_NONE;
      for (int i = `DFM_NUM_CODED - 1; i >= 0; i--)
      begin
         if (event_vec[i])
            new_code = 4'(i + 1);
      end
      if (system_fault_in)
         new_code = `DFM_CODE_SYSTEM;
   end

   assign fault_act = fault_code_q != `DFM_CODE_NONE;
   assign clearable = fault_code_q != `DFM_CODE_OVERCURRENT
      && fault_code_q != `DFM_CODE_MEMORY
      && fault_code_q != `DFM_CODE_SYSTEM;
   assign clear_ok = fault_act && clear_edge && clearable;

   // A fault that arrives with the clear edge is latched, not lost.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         fault_code_q <= `DFM_CODE_NONE;
      else if (!fault_act || clear_ok)
         fault_code_q <= new_code;
   end

   // ----------------------------------------------------------------------
   // Fault output and winding current
   // ----------------------------------------------------------------------
   assign fault_out = ~fault_act;
   assign winding_enable_out = ~fault_act & ~sync_q.coff;

   // ----------------------------------------------------------------------
   // Lamp code
   // ----------------------------------------------------------------------
   localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);
   localparam logic [31:0] PAUSE_LAST = 32'(PAUSE_CYCLES - 1);

   dfm_pkg::dfm_lamp_state_t lamp_state_q;
   logic [31:0] timer_q;
   logic [3:0] blink_num_q;

   always_ff @(posedge sys_clk)
   begin
      // A fault latched in the cycle of a clear starts a fresh group.
      if (reset || !fault_act || clear_ok)
      begin
         lamp_state_q <= dfm_pkg::DFM_LAMP_IDLE;
         timer_q <= '0;
         blink_num_q <= 4'h0;
      end
      else
      begin
         timer_q <= timer_q + 32'h1;
         case (lamp_state_q)
            dfm_pkg::DFM_LAMP_IDLE:
            begin
               timer_q <= 32'h1;
               blink_num_q <= 4'h1;
               if (fault_code_q == `DFM_CODE_SYSTEM)
                  lamp_state_q <= dfm_pkg::DFM_LAMP_STEADY;
               else
                  lamp_state_q <= dfm_pkg::DFM_LAMP_ON;
            end
            dfm_pkg::DFM_LAMP_ON:
            begin
               if (timer_q == BLINK_LAST)
               begin
                  timer_q <= '0;
                  if (blink_num_q >= fault_code_q)
                     lamp_state_q <= dfm_pkg::DFM_LAMP_PAUSE;
                  else
                     lamp_state_q <= dfm_pkg::DFM_LAMP_OFF;
               end
            end
            dfm_pkg::DFM_LAMP_OFF:
            begin
               if (timer_q == BLINK_LAST)
               begin
                  timer_q <= '0;
                  blink_num_q <= blink_num_q + 4'h1;
                  lamp_state_q <= dfm_pkg::DFM_LAMP_ON;
               end
            end
            dfm_pkg::DFM_LAMP_PAUSE:
            begin
               if (timer_q == PAUSE_LAST)
               begin
                  timer_q <= '0;
                  blink_num_q <= 4'h1;
                  lamp_state_q <= dfm_pkg::DFM_LAMP_ON;
               end
            end
            dfm_pkg::DFM_LAMP_STEADY:
               timer_q <= '0;
            default:
               lamp_state_q <= dfm_pkg::DFM_LAMP_IDLE;
         endcase
      end
   end

   // The lamp lights in the same cycle as the fault output drops.
   assign fault_lamp_out = fault_act
      && (lamp_state_q == dfm_pkg::DFM_LAMP_IDLE
      || lamp_state_q == dfm_pkg::DFM_LAMP_ON
      || lamp_state_q == dfm_pkg::DFM_LAMP_STEADY);

   // ----------------------------------------------------------------------
   // Step pulse decoding
   // ----------------------------------------------------------------------
   logic fwd_edge;
   logic rev_edge;
   logic step_edge;
   logic step_go;
   logic step_fwd;
   logic step_q;
   logic dir_q;
   logic [5:0] phase_q;
   logic timing_q;

   assign fwd_edge = sync_q.fwd & ~prev_q.fwd;
   assign rev_edge = sync_q.rev & ~prev_q.rev;
   assign step_edge = sync_q.step & ~prev_q.step;

   always_comb
   begin
      if (dual_mode_q)
      begin
         step_go = (fwd_edge | rev_edge)
            & ~(sync_q.fwd & sync_q.rev);
         step_fwd = fwd_edge;
      end
      else
      begin
         step_go = step_edge;
         step_fwd = sync_q.dir;
      end
   end

   // Steps are dropped while the winding is not excited.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         step_q <= 1'b0;
         dir_q <= 1'b0;
      end
      else
      begin
         step_q <= step_go & winding_enable_out & mode_valid_q;
         if (step_go)
            dir_q <= step_fwd;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         phase_q <= '0;
         timing_q <= 1'b0;
      end
      else
      begin
         if (step_q)
            phase_q <= (phase_q == `DFM_PHASE_LAST) ? 6'h0 : phase_q + 6'h1;
         // The multiplier gates the marker; a low input may hide it.
         timing_q <= (phase_q == 6'h0) && sync_q.mult;
      end
   end

   assign step_out = step_q;
   assign step_dir_out = dir_q;
   assign step_phase_timing_out = timing_q;

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   logic [`DFM_IRQ_BITS-1:0] irq_status_q;
   logic [`DFM_IRQ_BITS-1:0] irq_enable_q;
   logic [`DFM_IRQ_BITS-1:0] irq_event;
   logic [`DFM_IRQ_BITS-1:0] irq_clear;
   logic bus_ack_q;
   logic wr_take;

   assign wr_take = avs_write & bus_ack_q;

   always_comb
   begin
      irq_event = '0;
      irq_event[`DFM_IRQ_RAISE] = !fault_act && new_code != `DFM_CODE_NONE;
      irq_event[`DFM_IRQ_CLEARED] = clear_ok && new_code == `DFM_CODE_NONE;
      irq_clear = '0;
      if (wr_take && avs_address == `DFM_ADDR_IRQ_CLEAR)
         irq_clear = avs_writedata[`DFM_IRQ_BITS-1:0];
   end

   // Set wins over a clear written in the same cycle.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         irq_status_q <= '0;
      else
         irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         irq_enable_q <= '0;
      else if (wr_take && avs_address == `DFM_ADDR_IRQ_ENABLE)
         irq_enable_q <= avs_writedata[`DFM_IRQ_BITS-1:0];
   end

   assign irq = |(irq_status_q & irq_enable_q);

   // ----------------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------------
   // Every access takes one wait cycle, which lets read data come from a
   // flip-flop at the cost of one cycle of latency.
   logic [31:0] rdata_q;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         bus_ack_q <= 1'b0;
      else
         bus_ack_q <= (avs_read | avs_write) & ~bus_ack_q;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         rdata_q <= '0;
      else if (avs_read && !bus_ack_q)
      begin
         rdata_q <= '0;
         case (avs_address)
            `DFM_ADDR_STATUS:
            begin
               rdata_q[3:0] <= fault_code_q;
               rdata_q[`DFM_ST_ACTIVE] <= fault_act;
               rdata_q[`DFM_ST_DUAL] <= dual_mode_q;
               rdata_q[`DFM_ST_WIND] <= winding_enable_out;
            end
            `DFM_ADDR_IRQ_STATUS:
               rdata_q[`DFM_IRQ_BITS-1:0] <= irq_status_q;
            `DFM_ADDR_IRQ_ENABLE:
               rdata_q[`DFM_IRQ_BITS-1:0] <= irq_enable_q;
            default:
               rdata_q <= '0;
         endcase
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
   assign avs_readdata = rdata_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   logic no_new_fault;
   assign no_new_fault = new_code == `DFM_CODE_NONE;

   sequence s_fault_arrives;
      !fault_act && !no_new_fault;
   endsequence

   sequence s_blink_done;
      lamp_state_q == dfm_pkg::DFM_LAMP_ON && timer_q == BLINK_LAST
         && !clear_ok;
   endsequence

   property p_fault_drops;
      @(posedge sys_clk) disable iff (reset)
      s_fault_arrives |=> !fault_out && !winding_enable_out && fault_lamp_out;
   endproperty
   a_fault_drops: assert property (p_fault_drops)
      else $error("fault did not drop output, lamp and current together");

   property p_clear_once;
      @(posedge sys_clk) disable iff (reset)
      clear_ok && no_new_fault |=> fault_out && !clear_edge;
   endproperty
   a_clear_once: assert property (p_clear_once)
      else $error("fault clear pulse did not restore the fault output");

   property p_reset_clears;
      @(posedge sys_clk) reset |=> fault_out && fault_code_q == 4'h0;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("reset left a fault latched");

   property p_sticky;
      @(posedge sys_clk) disable iff (reset)
      fault_act && !clearable |=> $stable(fault_code_q);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("power-cycle fault was cleared");

   property p_blink_step;
      @(posedge sys_clk) disable iff (reset)
      s_blink_done ##0 fault_act ##1 fault_act |->
         lamp_state_q inside {dfm_pkg::DFM_LAMP_OFF, dfm_pkg::DFM_LAMP_PAUSE}
         && timer_q == 32'h0 && !fault_lamp_out;
   endproperty
   a_blink_step: assert property (p_blink_step)
      else $error("lit phase did not end after its length");

   property p_blink_count;
      @(posedge sys_clk) disable iff (reset)
      lamp_state_q == dfm_pkg::DFM_LAMP_ON |->
         blink_num_q >= 4'h1 && blink_num_q <= fault_code_q;
   endproperty
   a_blink_count: assert property (p_blink_count)
      else $error("blink count exceeds fault code");

   property p_steady;
      @(posedge sys_clk) disable iff (reset)
      fault_code_q == `DFM_CODE_SYSTEM |=> fault_lamp_out [*2];
   endproperty
   a_steady: assert property (p_steady)
      else $error("system fault lamp not steady");

   property p_overspeed;
      @(posedge sys_clk) disable iff (reset)
      !fault_act && overspeed && !system_fault_in
         && fault_event_in[4:0] == 5'h0
         |=> fault_code_q == `DFM_CODE_OVERSPEED;
   endproperty
   a_overspeed: assert property (p_overspeed)
      else $error("overspeed not latched as six blinks");

   property p_coff;
      @(posedge sys_clk) disable iff (reset)
      sync_q.coff |-> !winding_enable_out ##1 !step_out;
   endproperty
   a_coff: assert property (p_coff)
      else $error("winding excited while current-off asserted");

   property p_both_high;
      @(posedge sys_clk) disable iff (reset)
      dual_mode_q && sync_q.fwd && sync_q.rev |=> !step_out;
   endproperty
   a_both_high: assert property (p_both_high)
      else $error("step made with both pulse inputs high");

   property p_direction;
      @(posedge sys_clk) disable iff (reset)
      step_out && !dual_mode_q |-> step_dir_out == $past(sync_q.dir);
   endproperty
   a_direction: assert property (p_direction)
      else $error("single-pulse step direction wrong");

   property p_timing;
      @(posedge sys_clk) disable iff (reset)
      step_phase_timing_out |-> $past(sync_q.mult);
   endproperty
   a_timing: assert property (p_timing)
      else $error("timing marker without multiplier input");

   property p_mode_fixed;
      @(posedge sys_clk) disable iff (reset)
      mode_valid_q |=> $stable(dual_mode_q);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed)
      else $error("pulse mode changed while powered");

   property p_first_fault;
      @(posedge sys_clk) disable iff (reset)
      fault_act && !clear_ok |=> $stable(fault_code_q) && !winding_enable_out;
   endproperty
   a_first_fault: assert property (p_first_fault)
      else $error("latched fault changed without a clear");

endmodule

// File: bench/dfm_host_model.sv
// Host pulse controller model that drives the command pins of the drive.
`timescale 1ns/1ps

module dfm_host_model (
   input wire logic sys_clk,
   output dfm_pkg::dfm_host_pins_t pins
);
   // ----------------------------------------------------------------
   // Pin sequencing
   // ----------------------------------------------------------------
   // Every level is held three cycles so that the drive's two-flop
   // synchronisers never miss an edge; callers enter just after an edge.
   task automatic hold();
      repeat (3) @(posedge sys_clk);
   endtask

   initial
   begin
      pins = '0;
      pins.mult = 1'b1;
      pins.mode = 1'b1;
   end

   task automatic set_static(input logic coff, input logic mode);
      pins.coff <= coff;
      pins.mode <= mode;
      hold();
   endtask

   // Both inputs high at once is only sent when a scenario asks for it.
   task automatic pair_pulse(input logic fwd, input logic rev);
      pins.fwd <= fwd;
      pins.rev <= rev;
      hold();
      pins.fwd <= 1'b0;
      pins.rev <= 1'b0;
      hold();
   endtask

   task automatic step_pulse(input logic dir);
      pins.dir <= dir;
      hold();
      pins.step <= 1'b1;
      hold();
      pins.step <= 1'b0;
      hold();
   endtask

   task automatic set_mult(input logic mult);
      pins.mult <= mult;
      hold();
   endtask

   task automatic clear_pulse();
      pins.clr <= 1'b1;
      hold();
      pins.clr <= 1'b0;
      hold();
   endtask
endmodule

// File: bench/drive_fault_manager_tb.sv
// Self-checking testbench of the drive fault manager.
`timescale 1ns/1ps

`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("BAD %0t got %h expected %h", $time, got, exp); \
      end \
   end

module drive_fault_manager_tb;
   localparam int BLINK = 4;
   localparam int PAUSE = 24;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] fault_event_in = 8'h00;
   logic system_fault_in = 1'b0;
   logic [15:0] motor_speed_rpm_in = 16'h0000;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic fault_out, fault_lamp_out, winding_enable_out, irq;
   logic step_out, step_dir_out, step_phase_timing_out;
   dfm_pkg::dfm_host_pins_t host_pins;
   int n_errors = 0;
   int n_tests = 0;
   int n_steps = 0;

   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      if (step_out === 1'b1) n_steps++;
   end

   dfm_host_model i_dfm_host_model (.sys_clk(sys_clk), .pins(host_pins));

   dfm_top #(.BLINK_CYCLES(BLINK), .PAUSE_CYCLES(PAUSE)) i_dfm_top (
      .sys_clk(sys_clk), .reset(reset), .fault_clear_in(host_pins.clr),
      .forward_pulse_in(host_pins.fwd), .reverse_pulse_in(host_pins.rev),
      .step_pulse_in(host_pins.step), .direction_in(host_pins.dir),
      .current_off_in(host_pins.coff), .step_multiplier_in(host_pins.mult),
      .dual_pulse_mode(host_pins.mode), .fault_event_in(fault_event_in),
      .system_fault_in(system_fault_in),
      .motor_speed_rpm_in(motor_speed_rpm_in), .fault_out(fault_out),
      .fault_lamp_out(fault_lamp_out), .winding_enable_out(winding_enable_out),
      .step_out(step_out), .step_dir_out(step_dir_out),
      .step_phase_timing_out(step_phase_timing_out), .irq(irq),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   // ----------------------------------------------------------------
   // Common tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask

   // The request is held until waitrequest is seen low at an edge; only
   // the watchdog ends a wait that never gets its answer.
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h00000000, d);
      `CHK(d, e);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_codes();
      int r;
      logic prev;
      for (int k = 1; k <= 8; k++)
      begin
         do_reset();
         if (k == 1) wr(4'hC, 32'h00000001);
         if (k == 6)
         begin
            motor_speed_rpm_in <= 16'h1388;
            repeat (4) @(posedge sys_clk);
            `CHK(fault_out, 1'b1);
            motor_speed_rpm_in <= 16'h1389;
         end
         else
            fault_event_in <= 8'h01 << (k - 1);
         repeat (2) @(posedge sys_clk);
         `CHK(fault_out, 1'b0);
         `CHK(fault_lamp_out, 1'b1);
         `CHK(winding_enable_out, 1'b0);
         fault_event_in <= 8'h00;
         motor_speed_rpm_in <= 16'h0000;
         prev = 1'b1;
         r = 0;
         // Two full groups; a short pause would add extra rising edges.
         repeat (2 * (2 * BLINK * k - BLINK + PAUSE) - 4)
         begin
            @(posedge sys_clk);
            if (fault_lamp_out === 1'b1 && prev === 1'b0) r++;
            prev = fault_lamp_out;
         end
         `CHK(r, 2 * k - 1);
         fault_event_in <= 8'hFF;
         @(posedge sys_clk);
         fault_event_in <= 8'h00;
         if (k == 1)
         begin
            `CHK(irq, 1'b1);
            wr(4'h0, 32'h0000000F);
            rd_chk(4'h2, 32'h00000000);
         end
         rd_chk(4'h0, 32'h30 | 32'(k));
         i_dfm_host_model.clear_pulse();
         `CHK(fault_out, (k == 5 || k == 7) ? 1'b0 : 1'b1);
         if (k == 1)
         begin
            wr(4'h8, 32'h00000001);
            `CHK(irq, 1'b0);
            rd_chk(4'h4, 32'h00000002);
            wr(4'hC, 32'h00000002);
            `CHK(irq, 1'b1);
            rd_chk(4'hC, 32'h00000002);
            wr(4'h8, 32'h00000002);
            rd_chk(4'h4, 32'h00000000);
         end
      end
   endtask

   task automatic t_system();
      do_reset();
      system_fault_in <= 1'b1;
      @(posedge sys_clk);
      system_fault_in <= 1'b0;
      repeat (40) @(posedge sys_clk) `CHK(fault_lamp_out, 1'b1);
      rd_chk(4'h0, 32'h00000039);
      i_dfm_host_model.clear_pulse();
      `CHK(fault_out, 1'b0);
      do_reset();
      `CHK(fault_out, 1'b1);
      rd_chk(4'h0, 32'h00000060);
   endtask

   task automatic pulse_chk(input logic f, input logic r, input int inc);
      int s;
      s = n_steps;
      i_dfm_host_model.pair_pulse(f, r);
      repeat (2) @(posedge sys_clk);
      `CHK(n_steps, s + inc);
   endtask

   task automatic t_pulses();
      int s;
      do_reset();
      `CHK(step_phase_timing_out, 1'b1);
      i_dfm_host_model.set_mult(1'b0);
      @(posedge sys_clk);
      `CHK(step_phase_timing_out, 1'b0);
      i_dfm_host_model.set_mult(1'b1);
      pulse_chk(1'b1, 1'b0, 1);
      `CHK(step_dir_out, 1'b1);
      `CHK(step_phase_timing_out, 1'b0);
      pulse_chk(1'b0, 1'b1, 1);
      `CHK(step_dir_out, 1'b0);
      pulse_chk(1'b1, 1'b1, 0);
      i_dfm_host_model.set_static(1'b0, 1'b0);
      s = n_steps;
      i_dfm_host_model.step_pulse(1'b1);
      `CHK(n_steps, s);
      rd_chk(4'h0, 32'h00000060);
      i_dfm_host_model.set_static(1'b1, 1'b0);
      `CHK(winding_enable_out, 1'b0);
      pulse_chk(1'b1, 1'b0, 0);
      i_dfm_host_model.set_static(1'b0, 1'b0);
      `CHK(winding_enable_out, 1'b1);
      do_reset();
      rd_chk(4'h0, 32'h00000040);
      s = n_steps;
      i_dfm_host_model.step_pulse(1'b1);
      `CHK(step_dir_out, 1'b1);
      i_dfm_host_model.step_pulse(1'b0);
      `CHK(step_dir_out, 1'b0);
      `CHK(n_steps, s + 2);
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end

   initial
   begin
      do_reset();
      `CHK(fault_out, 1'b1);
      `CHK(fault_lamp_out, 1'b0);
      t_codes();
      t_system();
      t_pulses();
      stop_test();
   end
endmodule
